/* File: logic/tsw_defs.svh */
// Purpose: named constants of the time-slot switch memory window
// Assumes: 14-bit processor port address, 16-bit data
// Notes:   included by the package and the design modules
`ifndef TSW_DEFS_SVH
`define TSW_DEFS_SVH

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
`define TSW_ADDR_W        14
`define TSW_MEM_SPACE_BIT 13
`define TSW_STREAM_MSB    12
`define TSW_STREAM_LSB    8
`define TSW_CHAN_MSB      7
`define TSW_CHAN_LSB      0
`define TSW_CTRL_ADDR     13'h0000
`define TSW_RATE_BASE     13'h0020
`define TSW_RATE_TOP      13'h003F

// ----------------------------------------------------------------
// control register fields and reset
// ----------------------------------------------------------------
`define TSW_CTRL_MSEL_MSB 1
`define TSW_CTRL_MSEL_LSB 0
`define TSW_CTRL_VARIABLE_DELAY_GLOBAL_ENABLE    2
`define TSW_CTRL_RESET    16'h0000
`define TSW_RATE_RESET    2'h0
`define TSW_BASE_CHANNELS 9'h020

// ----------------------------------------------------------------
// connection word layout
// ----------------------------------------------------------------
`define TSW_CWL_MODE      0
`define TSW_CWL_SCA_MSB   8
`define TSW_CWL_SCA_LSB   1
`define TSW_CWL_SSA_MSB   13
`define TSW_CWL_SSA_LSB   9
`define TSW_CWL_VAR_DELAY 14
`define TSW_CWL_LAW_EN    15
`define TSW_CWL_PCC_MSB   2
`define TSW_CWL_PCC_LSB   1
`define TSW_CWH_OCL_MSB   1
`define TSW_CWH_OCL_LSB   0
`define TSW_CWH_ICL_MSB   3
`define TSW_CWH_ICL_LSB   2
`define TSW_CWH_VD        4
`define TSW_WORD_RESET    16'h0000
`define TSW_DATA_RESET    8'h00

`endif

/* File: logic/tsw_pkg.sv */
// Purpose: types shared by the switch memory window modules
// Assumes: tsw_defs.svh constants
// Notes:   decoded connection travels as one packed struct
`include "tsw_defs.svh"
package tsw_pkg;

  // memory picked by the control register select field
  typedef enum logic [1:0] {
    TSW_MEM_DATA,
    TSW_MEM_CWL,
    TSW_MEM_CWH,
    TSW_MEM_NONE
  } tsw_mem_t;

  // decoded per-output-channel connection
  typedef struct packed {
    logic       specialModeSelect;
    logic [1:0] specialMode;
    logic       variableDelay;
    logic [4:0] sourceStream;
    logic [7:0] sourceChannel;
    logic       lawConversionEnable;
    logic [1:0] inputCodingLaw;
    logic [1:0] outputCodingLaw;
    logic       dataClass;
  } tsw_cnx_t;

endpackage

/* File: logic/tsw_cnx_decode.sv */
// Purpose: splits a connection word pair into switching controls
// Assumes: words come straight from connection storage
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defs.svh"
module tsw_cnx_decode
(
  // connection words
  input  wire logic [15:0]      wordLow,
  input  wire logic [15:0]      wordHigh,
  // decoded connection
  output tsw_pkg::tsw_cnx_t     cnx
);
  import tsw_pkg::*;

  // mode bit picks normal switching or a special mode
  assign cnx.specialModeSelect = wordLow[`TSW_CWL_MODE];
  assign cnx.specialMode = wordLow[`TSW_CWL_MODE] ?
                           wordLow[`TSW_CWL_PCC_MSB:`TSW_CWL_PCC_LSB] : 2'h0;
  // source fields only mean something in normal switching
  assign cnx.variableDelay = ~wordLow[`TSW_CWL_MODE] &
                             wordLow[`TSW_CWL_VAR_DELAY];
  assign cnx.sourceStream  = wordLow[`TSW_CWL_MODE] ? 5'h00 :
                             wordLow[`TSW_CWL_SSA_MSB:`TSW_CWL_SSA_LSB];
  assign cnx.sourceChannel = wordLow[`TSW_CWL_MODE] ? 8'h00 :
                             wordLow[`TSW_CWL_SCA_MSB:`TSW_CWL_SCA_LSB];
  // coding laws come from the high word, the law enable from the low word
  assign cnx.lawConversionEnable = wordLow[`TSW_CWL_LAW_EN];
  assign cnx.inputCodingLaw  = wordHigh[`TSW_CWH_ICL_MSB:`TSW_CWH_ICL_LSB];
  assign cnx.outputCodingLaw = wordHigh[`TSW_CWH_OCL_MSB:`TSW_CWH_OCL_LSB];
  assign cnx.dataClass       = wordHigh[`TSW_CWH_VD];

endmodule
`default_nettype wire

/* File: logic/tsw_mem_window.sv */
// Purpose: processor window onto data and connection memories
// Assumes: synchronous single-cycle host strobes on clk_sys (20 MHz)
// Notes:   storage is flip-flops; a lookup port feeds the switch core
// How it works
// - high address bit routes to memories
// - control field picks data, low, high memory
// - slow rates limit channels to 31/63
// - faster rates limit channels to 127/255
// - mode bit clear means normal switching
// - delay bit clear picks constant delay
// - delay bit set picks variable delay, only while the mode bit is clear
// - mode bit set selects special mode
// - high word carries coding laws
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defs.svh"
module tsw_mem_window
#(
  parameter int STREAMS  = 32,
  parameter int CHANNELS = 256
)
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // processor port
  input  wire logic                   hostSel,
  input  wire logic                   hostWr,
  input  wire logic                   hostRd,
  input  wire logic [`TSW_ADDR_W-1:0] hostAddr,
  input  wire logic [15:0]            hostWrData,
  output logic      [15:0]            hostRdData,
  output logic                        hostRdValid,
  // input side fills the data memory
  input  wire logic                   dmWrEn,
  input  wire logic [4:0]             dmWrStream,
  input  wire logic [7:0]             dmWrChannel,
  input  wire logic [7:0]             dmWrData,
  // output side connection lookup
  input  wire logic                   lkValid,
  input  wire logic [4:0]             lkStream,
  input  wire logic [7:0]             lkChannel,
  output tsw_pkg::tsw_cnx_t           cnxOut,
  output logic                        cnxOutValid,
  // global variable delay enable
  output logic                        variableDelayGlobalEnable
);
  import tsw_pkg::*;

  localparam int SW    = $clog2(STREAMS);
  localparam int CW    = $clog2(CHANNELS);
  localparam int DEPTH = STREAMS * CHANNELS;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (STREAMS < 2 || STREAMS > 32 || (1 << SW) != STREAMS)
    $error("STREAMS must be a power of two from 2 to 32");
  if (CHANNELS < 32 || CHANNELS > 256 || (1 << CW) != CHANNELS)
    $error("CHANNELS must be a power of two from 32 to 256");

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [1:0]  rate_q   [STREAMS];
  logic [15:0] cwLow_q  [DEPTH];
  logic [15:0] cwHigh_q [DEPTH];
  logic [7:0]  data_q   [DEPTH];
  logic [15:0] rdData_q;
  logic        rdValid_q;
  tsw_cnx_t    cnx_q;
  logic        cnxValid_q;

  // channel fits the window that the stream's rate leaves open
  function automatic logic chanOk(input logic [1:0] rate, input logic [7:0] chan);
    logic [8:0] span;
    span = `TSW_BASE_CHANNELS << rate;
    return ({1'b0, chan} < span) && ({1'b0, chan} < 9'(CHANNELS));
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic        memSpace  = hostAddr[`TSW_MEM_SPACE_BIT];
  wire logic [4:0]  hStream   = hostAddr[`TSW_STREAM_MSB:`TSW_STREAM_LSB];
  wire logic [7:0]  hChan     = hostAddr[`TSW_CHAN_MSB:`TSW_CHAN_LSB];
  wire tsw_mem_t    memSel    = tsw_mem_t'(ctrl_q[`TSW_CTRL_MSEL_MSB:`TSW_CTRL_MSEL_LSB]);
  wire logic        hStreamOk = ({3'h0, hStream} < 8'(STREAMS));
  wire logic [1:0]  hRate     = hStreamOk ? rate_q[hStream[SW-1:0]] : 2'h0;
  wire logic        inRange   = hStreamOk && chanOk(hRate, hChan);
  wire logic [SW+CW-1:0] hIdx = {hStream[SW-1:0], hChan[CW-1:0]};
  wire logic [12:0] regAddr   = hostAddr[12:0];
  wire logic        isCtrl    = ~memSpace && (regAddr == `TSW_CTRL_ADDR);
  wire logic        isRate    = ~memSpace && (regAddr >= `TSW_RATE_BASE) &&
                                (regAddr < (`TSW_RATE_BASE + 13'(STREAMS)));
  wire logic [4:0]  rateIdx   = regAddr[4:0];
  wire logic        hWrite    = hostSel && hostWr;
  wire logic        hRead     = hostSel && hostRd && !hostWr;
  // writes to the data memory are dropped: the input side owns it
  wire logic        wrLow     = hWrite && memSpace && inRange && memSel == TSW_MEM_CWL;
  wire logic        wrHigh    = hWrite && memSpace && inRange && memSel == TSW_MEM_CWH;
  wire logic [SW+CW-1:0] dIdx = {dmWrStream[SW-1:0], dmWrChannel[CW-1:0]};
  wire logic        dStreamOk = ({3'h0, dmWrStream} < 8'(STREAMS));
  wire logic        dWrite    = dmWrEn && dStreamOk &&
                                chanOk(rate_q[dmWrStream[SW-1:0]], dmWrChannel);
  wire logic [SW+CW-1:0] lIdx = {lkStream[SW-1:0], lkChannel[CW-1:0]};

  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  // out-of-window channels and the spare select code read as zero
  wire logic [15:0] memRd =
      !inRange                 ? 16'h0000 :
      (memSel == TSW_MEM_DATA) ? {8'h00, data_q[hIdx]} :
      (memSel == TSW_MEM_CWL)  ? cwLow_q[hIdx] :
      (memSel == TSW_MEM_CWH)  ? cwHigh_q[hIdx] : 16'h0000;
  wire logic [15:0] regRd =
      isCtrl ? ctrl_q :
      isRate ? {14'h0000, rate_q[rateIdx[SW-1:0]]} : 16'h0000;
  wire logic [15:0] rdMux = memSpace ? memRd : regRd;

  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  // control word and per-stream rate codes
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_q <= `TSW_CTRL_RESET;
      for (int s = 0; s < STREAMS; s++)
        rate_q[s] <= `TSW_RATE_RESET;
    end
    else if (hWrite && isCtrl)
      ctrl_q <= hostWrData;
    else if (hWrite && isRate)
      rate_q[rateIdx[SW-1:0]] <= hostWrData[1:0];
  end

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  // reset clears every word so all channels start in normal switching
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        cwLow_q[i]  <= `TSW_WORD_RESET;
        cwHigh_q[i] <= `TSW_WORD_RESET;
        data_q[i]   <= `TSW_DATA_RESET;
      end
    end
    else
    begin
      if (wrLow)
        cwLow_q[hIdx] <= hostWrData;
      if (wrHigh)
        cwHigh_q[hIdx] <= hostWrData;
      if (dWrite)
        data_q[dIdx] <= dmWrData;
    end
  end

  // ----------------------------------------------------------------
  // host read answer, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdData_q  <= 16'h0000;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= hRead;
      if (hRead)
        rdData_q <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // connection lookup for the switch core
  // ----------------------------------------------------------------
  tsw_cnx_t cnxNow;

  tsw_cnx_decode u_decode
  (
    .wordLow  (cwLow_q[lIdx]),
    .wordHigh (cwHigh_q[lIdx]),
    .cnx      (cnxNow)
  );

  // registered so the core sees a clean word one cycle after asking
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnx_q      <= '0;
      cnxValid_q <= 1'b0;
    end
    else
    begin
      cnxValid_q <= lkValid;
      if (lkValid)
        cnx_q <= cnxNow;
    end
  end

  assign hostRdData  = rdData_q;
  assign hostRdValid = rdValid_q;
  assign cnxOut      = cnx_q;
  assign cnxOutValid = cnxValid_q;
  // the host sets this before any channel picks variable delay
  assign variableDelayGlobalEnable = ctrl_q[`TSW_CTRL_VARIABLE_DELAY_GLOBAL_ENABLE];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LOW_WRITE_LANDS: assert property (@(posedge clk_sys) disable iff (srst)
    wrLow |=> cwLow_q[$past(hIdx)] == $past(hostWrData))
    else $error("low connection word write lost");
  AST_OUT_OF_WINDOW_KEPT: assert property (@(posedge clk_sys) disable iff (srst)
    hWrite && memSpace && !inRange && hStreamOk && memSel == TSW_MEM_CWL
    |=> cwLow_q[$past(hIdx)] == $past(cwLow_q[hIdx]))
    else $error("write outside the rate window changed memory");
  AST_REG_SPACE_SEPARATE: assert property (@(posedge clk_sys) disable iff (srst)
    hWrite && !memSpace && inRange && memSel == TSW_MEM_CWL
    |=> cwLow_q[$past(hIdx)] == $past(cwLow_q[hIdx]))
    else $error("register access reached memory");
  AST_READ_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (srst)
    hRead |=> hostRdValid && hostRdData == $past(rdMux) ##1 !hostRdValid || $past(hRead))
    else $error("read answer late or wrong");
  AST_NORMAL_SOURCE: assert property (@(posedge clk_sys) disable iff (srst)
    lkValid && !cwLow_q[lIdx][`TSW_CWL_MODE] |=> cnxOutValid && !cnxOut.specialModeSelect
    && cnxOut.sourceStream == $past(cwLow_q[lIdx][`TSW_CWL_SSA_MSB:`TSW_CWL_SSA_LSB])
    && cnxOut.sourceChannel == $past(cwLow_q[lIdx][`TSW_CWL_SCA_MSB:`TSW_CWL_SCA_LSB]))
    else $error("normal connection decoded wrongly");
  AST_DELAY_SELECT: assert property (@(posedge clk_sys) disable iff (srst)
    lkValid && !cwLow_q[lIdx][`TSW_CWL_MODE]
    |=> cnxOut.variableDelay == $past(cwLow_q[lIdx][`TSW_CWL_VAR_DELAY]))
    else $error("delay memory choice wrong");
  AST_SPECIAL_MODE: assert property (@(posedge clk_sys) disable iff (srst)
    lkValid && cwLow_q[lIdx][`TSW_CWL_MODE]
    |=> cnxOut.specialModeSelect && !cnxOut.variableDelay && cnxOut.sourceStream == 5'h00)
    else $error("special mode not flagged");
  AST_CODING_LAWS: assert property (@(posedge clk_sys) disable iff (srst)
    lkValid |=> cnxOut.inputCodingLaw == $past(cwHigh_q[lIdx][`TSW_CWH_ICL_MSB:`TSW_CWH_ICL_LSB])
    && cnxOut.outputCodingLaw == $past(cwHigh_q[lIdx][`TSW_CWH_OCL_MSB:`TSW_CWH_OCL_LSB]))
    else $error("coding laws not taken from high word");
  AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
    hWrite && isCtrl |=> ctrl_q == $past(hostWrData) ##0
    variableDelayGlobalEnable == $past(hostWrData[`TSW_CTRL_VARIABLE_DELAY_GLOBAL_ENABLE]))
    else $error("control register write lost");

  COV_LOW_WRITE:   cover property (@(posedge clk_sys) disable iff (srst) wrLow ##2 hRead);
  COV_HIGH_WRITE:  cover property (@(posedge clk_sys) disable iff (srst) wrHigh);
  COV_VAR_LOOKUP:  cover property (@(posedge clk_sys) disable iff (srst)
    cnxOutValid && cnxOut.variableDelay);
  COV_OUT_WINDOW:  cover property (@(posedge clk_sys) disable iff (srst)
    hWrite && memSpace && !inRange);

endmodule
`default_nettype wire

/* File: bench/tsw_host_model.sv */
// Purpose: host processor model on the parallel port of the memory window
// Assumes: single-cycle strobes on clk_sys, one access at a time
// Notes:   released lines show the inverse of their last value, so stale data never matches
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defs.svh"
module tsw_host_model
(
  // clock
  input  wire logic                   clk_sys,
  // processor port
  output logic                        hostSel,
  output logic                        hostWr,
  output logic                        hostRd,
  output logic      [`TSW_ADDR_W-1:0] hostAddr,
  output logic      [15:0]            hostWrData,
  input  wire logic [15:0]            hostRdData,
  input  wire logic                   hostRdValid
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // idle bus at time zero
  initial
  begin
    hostSel = 1'b0;
    hostWr = 1'b0;
    hostRd = 1'b0;
    hostAddr = 14'h0000;
    hostWrData = 16'h0000;
  end

  // register space keeps the top address bit low
  function automatic logic [13:0] regAddr(input logic [12:0] n);
    return {1'b0, n};
  endfunction

  // memory space: top bit high, then stream, then channel
  function automatic logic [13:0] memAddr(input logic [4:0] s, input logic [7:0] ch);
    return {1'b1, s, ch};
  endfunction

  // drop strobes and scramble the lines after the taking edge
  task automatic releaseBus();
    hostSel <= 1'b0;
    hostWr <= 1'b0;
    hostRd <= 1'b0;
    hostAddr <= ~hostAddr;
    hostWrData <= ~hostWrData;
  endtask

  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    hostSel <= 1'b1;
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWrData <= d;
    @(posedge clk_sys);
    releaseBus();
  endtask

  // answer is sampled one edge after the taking edge
  task automatic rd(input logic [13:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    hostSel <= 1'b1;
    hostRd <= 1'b1;
    hostAddr <= a;
    @(posedge clk_sys);
    releaseBus();
    @(posedge clk_sys);
    v = hostRdValid;
    d = hostRdData;
  endtask
endmodule
`default_nettype wire

/* File: bench/tdm_connection_memory_access_test.sv */
// Purpose: self-checking bench of the switch memory window
// Assumes: STREAMS=2 so stream 2 and up is refused; host model drives the port
// Notes:   expectations come from the word layouts, never from the design
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defs.svh"
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tdm_connection_memory_access_test;
  import tsw_pkg::*;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  logic        clk_sys, srst, hostSel, hostWr, hostRd, hostRdValid;
  logic [13:0] hostAddr;
  logic [15:0] hostWrData, hostRdData;
  logic        dmWrEn, lkValid, cnxOutValid, variableDelayGlobalEnable;
  logic [4:0]  dmWrStream, lkStream;
  logic [7:0]  dmWrChannel, dmWrData, lkChannel;
  tsw_cnx_t    cnxOut;
  int          miscompares, total_checks;

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  tsw_mem_window #(.STREAMS(2), .CHANNELS(256)) dut
  (
    .clk_sys(clk_sys), .srst(srst), .hostSel(hostSel), .hostWr(hostWr), .hostRd(hostRd),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .dmWrEn(dmWrEn), .dmWrStream(dmWrStream),
    .dmWrChannel(dmWrChannel), .dmWrData(dmWrData), .lkValid(lkValid),
    .lkStream(lkStream), .lkChannel(lkChannel), .cnxOut(cnxOut),
    .cnxOutValid(cnxOutValid), .variableDelayGlobalEnable(variableDelayGlobalEnable)
  );

  tsw_host_model host
  (
    .clk_sys(clk_sys), .hostSel(hostSel), .hostWr(hostWr), .hostRd(hostRd),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid)
  );

  task automatic rdChk(input logic [13:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    logic        v;
    host.rd(a, d, v);
    `CHK({nm, " valid"}, 1'b1, v)
    `CHK(nm, e, d)
  endtask

  // one more edge so the new control value stands before anyone looks at it
  task automatic ctrl(input logic [15:0] v);
    host.wr(host.regAddr(`TSW_CTRL_ADDR), v);
    @(posedge clk_sys);
  endtask

  // input side byte, taken at the edge after it is driven
  task automatic dmWrite(input logic [4:0] s, input logic [7:0] ch, input logic [7:0] d);
    @(posedge clk_sys);
    dmWrEn <= 1'b1;
    dmWrStream <= s;
    dmWrChannel <= ch;
    dmWrData <= d;
    @(posedge clk_sys);
    dmWrEn <= 1'b0;
    dmWrData <= ~d;
  endtask

  // lookup answer is taken one edge after the request edge
  task automatic lookup(input logic [4:0] s, input logic [7:0] ch);
    @(posedge clk_sys);
    lkValid <= 1'b1;
    lkStream <= s;
    lkChannel <= ch;
    @(posedge clk_sys);
    lkValid <= 1'b0;
    lkStream <= ~s;
    lkChannel <= ~ch;
    @(posedge clk_sys);
    `CHK("cnx valid", 1'b1, cnxOutValid)
  endtask

  task automatic testReset();
    `CHK("vd global", 1'b0, variableDelayGlobalEnable)
    rdChk(host.regAddr(`TSW_CTRL_ADDR), 16'h0000, "ctrl");
    rdChk(host.regAddr(13'h0021), 16'h0000, "rate");
    ctrl(16'h0001);
    rdChk(host.memAddr(5'h00, 8'h05), 16'h0000, "cwl reset");
    host.wr(host.regAddr(13'h0010), 16'hFFFF);
    rdChk(host.regAddr(13'h0010), 16'h0000, "unmapped");
    $display("test reset done");
  endtask

  task automatic testSelect();
    dmWrite(5'h00, 8'h03, 8'hA5);
    host.wr(host.memAddr(5'h00, 8'h03), 16'h1357);
    ctrl(16'h0002);
    host.wr(host.memAddr(5'h00, 8'h03), 16'h0A2C);
    rdChk(host.memAddr(5'h00, 8'h03), 16'h0A2C, "cwh");
    ctrl(16'h0003);
    host.wr(host.memAddr(5'h00, 8'h03), 16'hFFFF);
    rdChk(host.memAddr(5'h00, 8'h03), 16'h0000, "sel none");
    ctrl(16'h0000);
    host.wr(host.memAddr(5'h00, 8'h03), 16'hFFFF);
    rdChk(host.memAddr(5'h00, 8'h03), 16'h00A5, "data mem");
    dmWrite(5'h00, 8'h20, 8'h5A);
    host.wr(host.regAddr(13'h0020), 16'h0001);
    rdChk(host.memAddr(5'h00, 8'h20), 16'h0000, "data refused");
    dmWrite(5'h00, 8'h20, 8'h5A);
    rdChk(host.memAddr(5'h00, 8'h20), 16'h005A, "data widened");
    ctrl(16'h0001);
    rdChk(host.memAddr(5'h00, 8'h03), 16'h1357, "cwl");
    host.wr(host.memAddr(5'h00, 8'h00), 16'h1234);
    rdChk(host.regAddr(`TSW_CTRL_ADDR), 16'h0001, "ctrl kept");
    rdChk(host.memAddr(5'h00, 8'h00), 16'h1234, "cwl ch0");
    $display("test select done");
  endtask

  // each rate: last channel in window kept; first channel beyond refused for rates 0 to 2
  task automatic testRate();
    int lim;
    for (int r = 0; r < 4; r++)
    begin
      lim = 32 << r;
      host.wr(host.regAddr(13'h0021), 16'(r));
      host.wr(host.memAddr(5'h01, 8'(lim - 1)), 16'h0100 + 16'(r));
      rdChk(host.memAddr(5'h01, 8'(lim - 1)), 16'h0100 + 16'(r), "window top");
      if (lim < 256)
      begin
        host.wr(host.memAddr(5'h01, 8'(lim)), 16'hFFFF);
        rdChk(host.memAddr(5'h01, 8'(lim)), 16'h0000, "beyond window");
      end
    end
    host.wr(host.memAddr(5'h02, 8'h00), 16'hFFFF);
    rdChk(host.memAddr(5'h02, 8'h00), 16'h0000, "stream range");
    $display("test rate done");
  endtask

  task automatic testLookup();
    ctrl(16'h0006);
    `CHK("vd global", 1'b1, variableDelayGlobalEnable)
    host.wr(host.memAddr(5'h01, 8'h07), 16'h001B);
    ctrl(16'h0005);
    host.wr(host.memAddr(5'h01, 8'h07), 16'hEB86);
    lookup(5'h01, 8'h07);
    `CHK("mode", 1'b0, cnxOut.specialModeSelect)
    `CHK("var", 1'b1, cnxOut.variableDelay)
    `CHK("src stream", 5'h15, cnxOut.sourceStream)
    `CHK("src chan", 8'hC3, cnxOut.sourceChannel)
    `CHK("law en", 1'b1, cnxOut.lawConversionEnable)
    `CHK("icl", 2'h2, cnxOut.inputCodingLaw)
    `CHK("ocl", 2'h3, cnxOut.outputCodingLaw)
    `CHK("class", 1'b1, cnxOut.dataClass)
    host.wr(host.memAddr(5'h00, 8'h09), 16'h0042);
    lookup(5'h00, 8'h09);
    `CHK("const", 1'b0, cnxOut.variableDelay)
    `CHK("src chan", 8'h21, cnxOut.sourceChannel)
    for (int p = 0; p < 4; p++)
    begin
      host.wr(host.memAddr(5'h00, 8'h09), 16'h7E29 | 16'(p << 1));
      lookup(5'h00, 8'h09);
      `CHK("special", 1'b1, cnxOut.specialModeSelect)
      `CHK("pcc", 2'(p), cnxOut.specialMode)
      `CHK("no var", 1'b0, cnxOut.variableDelay)
      `CHK("no src", 5'h00, cnxOut.sourceStream)
    end
    ctrl(16'h0000);
    `CHK("vd off", 1'b0, variableDelayGlobalEnable)
    $display("test lookup done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    srst = 1'b1;
    dmWrEn = 1'b0;
    dmWrStream = 5'h00;
    dmWrChannel = 8'h00;
    dmWrData = 8'h00;
    lkValid = 1'b0;
    lkStream = 5'h00;
    lkChannel = 8'h00;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    testReset();
    testSelect();
    testRate();
    testLookup();
    tally_and_finish();
  end
endmodule
`default_nettype wire
